// File: verilog/pulse_front.sv
// constants package and the per-channel input conditioning module
`timescale 1ns/100ps
`default_nettype none

package pca_pkg;
  localparam int NUM_CH = 4;
  localparam int CFG_W = 8;
  localparam int CLK_HZ = 250_000_000;
  localparam int CLK_PER_US = CLK_HZ / 1_000_000;
  localparam int TICK_MS = 100;
  localparam int TICK_CYC = TICK_MS * (CLK_HZ / 1000);
  localparam int CLOSE_US = 3000;
  localparam int CLOSE_CYC = CLOSE_US * CLK_PER_US;
  localparam int OPEN_US = 4000;
  localparam int OPEN_CYC = OPEN_US * CLK_PER_US;
  localparam logic [7:0] CNT8_MAX = 8'hFF;
  localparam logic [15:0] ACC_MAX = 16'hFFFF;
  localparam logic [7:0] CODE_RADIX = 8'h0A;
  localparam logic [1:0] OPT_NONE = 2'h0;
  localparam logic [1:0] OPT_DISCARD = 2'h1;
  localparam logic [1:0] OPT_FREQ = 2'h2;
  typedef enum logic [2:0] {IN_HF, IN_AC, IN_SW, IN_HF16, IN_AC16} in_type_t;
endpackage

module pulse_front #(
  parameter int CLOSE_CYC = pca_pkg::CLOSE_CYC,
  parameter int OPEN_CYC = pca_pkg::OPEN_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire pca_pkg::in_type_t in_type,
  input wire logic above_high,
  input wire logic below_low,
  input wire logic ac_level,
  input wire logic sw_closed,
  output logic count_pulse
);
  typedef enum logic [1:0] {SW_OPEN, SW_CLOSING, SW_CLOSED, SW_OPENING}
    sw_state_t;

  sw_state_t sw_q;
  sw_state_t sw_d;
  logic [31:0] timer_q;
  logic [31:0] timer_d;
  logic hf_armed_q;
  logic ac_prev_q;
  logic sw_hit;
  logic is_hf;
  logic is_ac;
  logic hf_hit;
  logic ac_hit;

  // a one-cycle closure time would count on the first sample in SW_CLOSING
  if (CLOSE_CYC < 2 || OPEN_CYC < 1)
  begin : g_bad_param
    $error("pulse_front: switch timing counts too small");
  end

  assign is_hf = (in_type == pca_pkg::IN_HF) || (in_type == pca_pkg::IN_HF16);
  assign is_ac = (in_type == pca_pkg::IN_AC) || (in_type == pca_pkg::IN_AC16);
  // a count needs a pass below the low level, then above the high level
  assign hf_hit = is_hf && hf_armed_q && above_high;
  assign ac_hit = is_ac && ac_level && !ac_prev_q;
  assign sw_hit = (sw_q == SW_CLOSING) && sw_closed &&
                  (timer_q == 32'(CLOSE_CYC - 1));

  // closure must last the close time; reopening needs the open time, so
  // short open bounces return to the closed state without a count
  always_comb
  begin
    sw_d = sw_q;
    timer_d = timer_q + 32'h1;
    case (sw_q)
      SW_OPEN:
      begin
        timer_d = 32'h0;
        if (sw_closed)
          sw_d = SW_CLOSING;
      end
      SW_CLOSING:
      begin
        if (!sw_closed)
          sw_d = SW_OPEN;
        else if (sw_hit)
          sw_d = SW_CLOSED;
      end
      SW_CLOSED:
      begin
        timer_d = 32'h0;
        if (!sw_closed)
          sw_d = SW_OPENING;
      end
      default:
      begin
        if (sw_closed)
          sw_d = SW_CLOSED;
        else if (timer_q == 32'(OPEN_CYC - 1))
          sw_d = SW_OPEN;
      end
    endcase
    if (in_type != pca_pkg::IN_SW)
      sw_d = SW_OPEN;
  end

  // sampled every clock, so pulses down to one period are seen
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      sw_q <= SW_OPEN;
      timer_q <= 32'h0;
      hf_armed_q <= 1'b0;
      ac_prev_q <= 1'b0;
      count_pulse <= 1'b0;
    end
    else
    begin
      sw_q <= sw_d;
      timer_q <= timer_d;
      hf_armed_q <= below_low || (hf_armed_q && !above_high);
      ac_prev_q <= ac_level;
      count_pulse <= hf_hit || ac_hit || sw_hit;
    end
  end

  chk_sw_close_time: assert property (
    @(posedge clk) disable iff (!rstn)
    sw_hit |-> $past(sw_q) == SW_CLOSING)
    else $error("switch count without a full closure");
  chk_hf_threshold: assert property (
    @(posedge clk) disable iff (!rstn)
    hf_hit |-> $past(hf_armed_q) || $past(below_low))
    else $error("high frequency count without low crossing");
endmodule // pulse_front

`default_nettype wire

// File: verilog/pulse_count_accumulator.sv
// four-channel pulse counter with accumulators, buffers and scaling
// How it works
// - high-frequency count on a rise from below low to above high
// - high-frequency inputs are sampled every clock, catching narrow pulses
// - switch closure counts after 3 ms closed; 4 ms open rearms
// - four input channels, each with its own eight-bit counter
// - eight-bit counters stop at 255 within one tick interval
// - sixteen-bit mode chains channel 0 or 2 with its partner
// - pairs are independent: two wide, or one wide and two narrow
// - each 0.1 s tick adds counters into accumulators and clears them
// - table start copies accumulator into buffer and clears it
// - pulse instruction scales buffer by multiplier plus offset
// - the buffer is replaced, never summed, on each table start
// - discard option keeps old buffer when an execution was skipped
// - frequency option divides count by the interval in seconds
// - a time change restarts the tick interval, keeping all counts
// - configuration ones digit selects the input type
// - configuration tens digit selects discard and frequency options
`timescale 1ns/100ps
`default_nettype none

module pulse_count_accumulator #(
  parameter int TICK_CYC = pca_pkg::TICK_CYC,
  parameter int CLOSE_CYC = pca_pkg::CLOSE_CYC,
  parameter int OPEN_CYC = pca_pkg::OPEN_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] above_high,
  input wire logic [3:0] below_low,
  input wire logic [3:0] ac_level,
  input wire logic [3:0] sw_closed,
  input wire logic [31:0] cfg_code,
  input wire logic table_start,
  input wire logic table_skipped,
  input wire logic time_changed,
  input wire logic instr_exec,
  input wire logic [1:0] instr_ch,
  input wire logic signed [15:0] multiplier,
  input wire logic signed [31:0] offset,
  input wire logic [15:0] interval_s,
  output logic signed [31:0] result,
  output logic result_valid,
  output logic [1:0] result_ch,
  output logic [3:0] chan_unavail,
  output logic tick
);
  localparam int N = pca_pkg::NUM_CH;

  if (TICK_CYC < 2 || CLOSE_CYC < 2 || OPEN_CYC < 1)
  begin : g_bad_param
    $error("pulse_count_accumulator: timing counts too small");
  end

  function automatic logic [7:0] sat8(input logic [7:0] a,
                                      input logic inc);
    sat8 = (a == pca_pkg::CNT8_MAX) ? a : a + {7'h0, inc};
  endfunction

  function automatic logic [15:0] sat16(input logic [15:0] a,
                                        input logic [15:0] b);
    logic [16:0] s;
    s = {1'b0, a} + {1'b0, b};
    sat16 = s[16] ? pca_pkg::ACC_MAX : s[15:0];
  endfunction

  function automatic pca_pkg::in_type_t dec_type(input logic [7:0] code);
    logic [7:0] t;
    t = code % pca_pkg::CODE_RADIX;
    case (t)
      8'h01: dec_type = pca_pkg::IN_AC;
      8'h02: dec_type = pca_pkg::IN_SW;
      8'h03: dec_type = pca_pkg::IN_HF16;
      8'h04: dec_type = pca_pkg::IN_AC16;
      default: dec_type = pca_pkg::IN_HF;
    endcase
  endfunction

  function automatic logic [1:0] dec_opt(input logic [7:0] code);
    logic [7:0] t;
    t = code / pca_pkg::CODE_RADIX;
    if (t == 8'h01)
      dec_opt = pca_pkg::OPT_DISCARD;
    else if (t == 8'h02)
      dec_opt = pca_pkg::OPT_FREQ;
    else
      dec_opt = pca_pkg::OPT_NONE;
  endfunction

  pca_pkg::in_type_t ch_type [N];
  logic [1:0] ch_opt [N];
  logic [N-1:0] ev;
  logic [N-1:0] ev_raw;
  logic [1:0] pair16;
  logic [N-1:0] discard;
  logic [7:0] cnt_q [N];
  logic [7:0] cnt_d [N];
  logic [15:0] add [N];
  logic [15:0] acc_q [N];
  logic [15:0] acc_d [N];
  logic [15:0] buf_q [N];
  logic [15:0] buf_d [N];
  logic [31:0] tick_cnt_q;
  logic tick_now;
  logic [15:0] sel_buf;
  logic [15:0] div_by;
  logic [15:0] sel_val;
  logic signed [33:0] scaled;
  logic [3:0] unavail_d;

  // configuration decode and input conditioning per channel
  for (genvar c = 0; c < N; c++)
  begin : g_ch
    assign ch_type[c] = dec_type(cfg_code[c*8 +: 8]);
    assign ch_opt[c] = dec_opt(cfg_code[c*8 +: 8]);
    assign discard[c] = ch_opt[c] != pca_pkg::OPT_NONE;
    pulse_front #(
      .CLOSE_CYC(CLOSE_CYC),
      .OPEN_CYC(OPEN_CYC)
    ) u_front (
      .clk(clk),
      .rstn(rstn),
      .in_type(ch_type[c]),
      .above_high(above_high[c]),
      .below_low(below_low[c]),
      .ac_level(ac_level[c]),
      .sw_closed(sw_closed[c]),
      .count_pulse(ev_raw[c])
    );
  end

  chk_type_decode: assert property (
    @(posedge clk) disable iff (!rstn)
    cfg_code[15:8] == 8'h02 |-> ch_type[1] == pca_pkg::IN_SW)
    else $error("switch closure code not decoded");
  chk_opt_decode: assert property (
    @(posedge clk) disable iff (!rstn)
    cfg_code[7:0] == 8'h14 |->
    ch_type[0] == pca_pkg::IN_HF && ch_opt[0] == pca_pkg::OPT_FREQ)
    else $error("frequency option code not decoded");

  // a wide channel lives on the even-numbered input of each pair
  assign pair16[0] = (ch_type[0] == pca_pkg::IN_HF16) ||
                     (ch_type[0] == pca_pkg::IN_AC16);
  assign pair16[1] = (ch_type[2] == pca_pkg::IN_HF16) ||
                     (ch_type[2] == pca_pkg::IN_AC16);
  assign ev = ev_raw & ~{pair16[1], 1'b0, pair16[0], 1'b0};
  assign unavail_d = {pair16[1], 1'b0, pair16[0], 1'b0};

  chk_wide_unavail: assert property (
    @(posedge clk) disable iff (!rstn)
    pair16[1] |=> chan_unavail[3] && !chan_unavail[2] && !chan_unavail[0])
    else $error("second wide pair not reported");

  // tick interval; a time change restarts it, counters keep their pulses
  assign tick_now = (tick_cnt_q == 32'(TICK_CYC - 1));

  always_ff @(posedge clk)
  begin
    if (!rstn || time_changed)
      tick_cnt_q <= 32'h0;
    else if (tick_now)
      tick_cnt_q <= 32'h0;
    else
      tick_cnt_q <= tick_cnt_q + 32'h1;
  end

  chk_tick_output: assert property (
    @(posedge clk) disable iff (!rstn)
    tick_now |=> tick ##1 !tick)
    else $error("tick output not a single pulse");

  // counters, chained in pairs when a wide channel is selected
  always_comb
  begin
    logic [15:0] comb;
    logic [15:0] nxt;
    comb = 16'h0;
    nxt = 16'h0;
    for (int p = 0; p < 2; p++)
    begin
      if (pair16[p])
      begin
        comb = {cnt_q[2*p+1], cnt_q[2*p]};
        nxt = tick_now ? {15'h0, ev[2*p]} :
              sat16(comb, {15'h0, ev[2*p]});
        add[2*p] = tick_now ? comb : 16'h0;
        add[2*p+1] = 16'h0;
        cnt_d[2*p] = nxt[7:0];
        cnt_d[2*p+1] = nxt[15:8];
      end
      else
      begin
        for (int k = 0; k < 2; k++)
        begin
          add[2*p+k] = tick_now ? {8'h0, cnt_q[2*p+k]} : 16'h0;
          cnt_d[2*p+k] = tick_now ? {7'h0, ev[2*p+k]} :
                         sat8(cnt_q[2*p+k], ev[2*p+k]);
        end
      end
    end
  end

  chk_pair_count: assert property (
    @(posedge clk) disable iff (!rstn)
    pair16[0] && !tick_now && ev[0] &&
    {cnt_q[1], cnt_q[0]} != pca_pkg::ACC_MAX |=>
    {cnt_q[1], cnt_q[0]} == $past({cnt_q[1], cnt_q[0]}) + 16'h1)
    else $error("wide counter missed a pulse");
  chk_pair_ignores: assert property (
    @(posedge clk) disable iff (!rstn)
    pair16[0] && !tick_now && !ev[0] && ev_raw[1] |=>
    $stable({cnt_q[1], cnt_q[0]}))
    else $error("partner input changed the wide counter");
  chk_cnt8_count: assert property (
    @(posedge clk) disable iff (!rstn)
    !pair16[1] && !tick_now && ev[3] && cnt_q[3] != pca_pkg::CNT8_MAX |=>
    cnt_q[3] == $past(cnt_q[3]) + 8'h1)
    else $error("eight-bit counter missed a pulse");

  // accumulators and holding buffers
  always_comb
  begin
    for (int c = 0; c < N; c++)
    begin
      acc_d[c] = table_start ? add[c] :
                 sat16(acc_q[c], add[c]);
      if (table_start && !(discard[c] && table_skipped))
        buf_d[c] = acc_q[c];
      else
        buf_d[c] = buf_q[c];
    end
  end

  always_ff @(posedge clk)
  begin
    for (int c = 0; c < N; c++)
    begin
      if (!rstn)
      begin
        cnt_q[c] <= 8'h0;
        acc_q[c] <= 16'h0;
        buf_q[c] <= 16'h0;
      end
      else
      begin
        cnt_q[c] <= cnt_d[c];
        acc_q[c] <= acc_d[c];
        buf_q[c] <= buf_d[c];
      end
    end
  end

  // scaling of the held count for the selected channel
  assign sel_buf = buf_q[instr_ch];
  assign div_by = (interval_s == 16'h0) ? 16'h1 : interval_s;
  assign sel_val = (ch_opt[instr_ch] == pca_pkg::OPT_FREQ) ?
                   sel_buf / div_by : sel_buf;
  assign scaled = 34'(signed'({1'b0, sel_val}) * multiplier) +
                  34'(offset);

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      result <= 32'sh0;
      result_valid <= 1'b0;
      result_ch <= 2'h0;
      chan_unavail <= 4'h0;
      tick <= 1'b0;
    end
    else
    begin
      if (instr_exec)
      begin
        result <= scaled[31:0];
        result_ch <= instr_ch;
      end
      result_valid <= instr_exec;
      chan_unavail <= unavail_d;
      tick <= tick_now;
    end
  end

  chk_tick_clears_cnt: assert property (
    @(posedge clk) disable iff (!rstn)
    tick_now && !pair16[0] |=> cnt_q[0] == {7'h0, $past(ev[0])})
    else $error("counter not cleared on tick");
  chk_tick_adds_acc: assert property (
    @(posedge clk) disable iff (!rstn)
    tick_now && !table_start && !pair16[0] |=>
    acc_q[0] == sat16($past(acc_q[0]), {8'h0, $past(cnt_q[0])}))
    else $error("accumulator missed tick transfer");
  chk_start_copies: assert property (
    @(posedge clk) disable iff (!rstn)
    table_start && !(discard[1] && table_skipped) |=>
    buf_q[1] == $past(acc_q[1]))
    else $error("buffer not loaded at table start");
  chk_start_zeroes: assert property (
    @(posedge clk) disable iff (!rstn)
    table_start && !tick_now |=> acc_q[2] == 16'h0)
    else $error("accumulator not cleared at table start");
  chk_discard_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    table_start && table_skipped && discard[0] |=> $stable(buf_q[0]))
    else $error("discarded interval replaced the buffer");
  chk_acc_saturate: assert property (
    @(posedge clk) disable iff (!rstn)
    acc_q[3] == pca_pkg::ACC_MAX && !table_start |=>
    acc_q[3] == pca_pkg::ACC_MAX)
    else $error("accumulator wrapped");
  chk_cnt8_saturate: assert property (
    @(posedge clk) disable iff (!rstn)
    cnt_q[3] == pca_pkg::CNT8_MAX && !tick_now && !pair16[1] |=>
    cnt_q[3] == pca_pkg::CNT8_MAX)
    else $error("eight-bit counter wrapped");
  chk_pair_unavail: assert property (
    @(posedge clk) disable iff (!rstn)
    pair16[0] |=> chan_unavail[1] && acc_q[1] == 16'h0 ##0
    $past(pair16[0]))
    else $error("partner channel still in use");
  chk_time_restart: assert property (
    @(posedge clk) disable iff (!rstn)
    time_changed |=> tick_cnt_q == 32'h0 ##1 !tick_now)
    else $error("tick interval not restarted");
  chk_result_strobe: assert property (
    @(posedge clk) disable iff (!rstn)
    instr_exec |=> result_valid && result_ch == $past(instr_ch))
    else $error("result not presented after instruction");
  chk_result_value: assert property (
    @(posedge clk) disable iff (!rstn)
    instr_exec && ch_opt[instr_ch] != pca_pkg::OPT_FREQ |=>
    result == 32'(signed'({16'h0, $past(buf_q[instr_ch])}) *
    $past(multiplier) + $past(offset)))
    else $error("result differs from count times multiplier plus offset");
  chk_freq_value: assert property (
    @(posedge clk) disable iff (!rstn)
    ch_opt[instr_ch] == pca_pkg::OPT_FREQ && interval_s != 16'h0 |->
    32'(sel_val) * 32'(interval_s) <= 32'(sel_buf) &&
    32'(sel_buf) < (32'(sel_val) + 32'h1) * 32'(interval_s))
    else $error("frequency is not count over interval");
  chk_result_hold: assert property (
    @(posedge clk) disable iff (!rstn)
    !instr_exec |=> !result_valid && $stable(result))
    else $error("result changed without an instruction");
endmodule // pulse_count_accumulator

`default_nettype wire

// File: sim/pulse_source.sv
// behavioural comparator, ac and switch sources for four channels
`timescale 1ns/100ps
`default_nettype none

module pulse_source (
  input wire logic clk,
  output logic [3:0] above_high,
  output logic [3:0] below_low,
  output logic [3:0] ac_level,
  output logic [3:0] sw_closed
);
  initial
  begin
    above_high = 4'h0;
    below_low = 4'hF;
    ac_level = 4'h0;
    sw_closed = 4'h0;
  end

  // every task toggles its lines away from idle and back again
  // idle below low, cross the dead band, two cycles above high
  task automatic hf(input int c);
    @(negedge clk);
    below_low[c] = ~below_low[c];
    @(negedge clk);
    above_high[c] = ~above_high[c];
    repeat (2) @(negedge clk);
    above_high[c] = ~above_high[c];
    @(negedge clk);
    below_low[c] = ~below_low[c];
    @(negedge clk);
  endtask

  task automatic ac(input int c);
    @(negedge clk);
    ac_level[c] = ~ac_level[c];
    repeat (2) @(negedge clk);
    ac_level[c] = ~ac_level[c];
    repeat (2) @(negedge clk);
  endtask

  // closed for cl cycles, then open for op cycles
  task automatic sw(input int c, input int cl, input int op);
    @(negedge clk);
    sw_closed[c] = ~sw_closed[c];
    repeat (cl) @(negedge clk);
    sw_closed[c] = ~sw_closed[c];
    repeat (op) @(negedge clk);
  endtask
endmodule // pulse_source

`default_nettype wire

// File: sim/tb_pulse_count_accumulator.sv
// self-checking bench for the pulse count accumulator
`timescale 1ns/100ps
`default_nettype none

module tb_pulse_count_accumulator;
  localparam int TK = 20;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [31:0] cfg_code = 32'h0;
  logic table_start = 1'b0;
  logic table_skipped = 1'b0;
  logic time_changed = 1'b0;
  logic instr_exec = 1'b0;
  logic [1:0] instr_ch = 2'h0;
  logic signed [15:0] multiplier = 16'h0001;
  logic signed [31:0] offset = 32'h0;
  logic [15:0] interval_s = 16'h0001;
  wire logic [3:0] above_high;
  wire logic [3:0] below_low;
  wire logic [3:0] ac_level;
  wire logic [3:0] sw_closed;
  logic signed [31:0] result;
  logic result_valid;
  logic [1:0] result_ch;
  logic [3:0] chan_unavail;
  logic tick;
  int fails = 0;
  int cmp_count = 0;
  int seed = 19;
  int cyc = 0;
  int n;
  logic [33:0] e;
  logic [33:0] exp_q[$];

  always #2 clk = ~clk;

  pulse_source u_pulse_source (
    .clk(clk), .above_high(above_high), .below_low(below_low),
    .ac_level(ac_level), .sw_closed(sw_closed)
  );

  pulse_count_accumulator #(.TICK_CYC(TK), .CLOSE_CYC(6), .OPEN_CYC(8))
    u_pulse_count_accumulator (
    .clk(clk), .rstn(rstn), .above_high(above_high),
    .below_low(below_low), .ac_level(ac_level), .sw_closed(sw_closed),
    .cfg_code(cfg_code), .table_start(table_start),
    .table_skipped(table_skipped), .time_changed(time_changed),
    .instr_exec(instr_exec), .instr_ch(instr_ch),
    .multiplier(multiplier), .offset(offset), .interval_s(interval_s),
    .result(result), .result_valid(result_valid), .result_ch(result_ch),
    .chan_unavail(chan_unavail), .tick(tick)
  );

  task print_verdict;
    if (exp_q.size() != 0)
      fails++;
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task chk(input logic [33:0] g, input logic [33:0] x);
    cmp_count++;
    if (g !== x)
    begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask

  always @(negedge clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      fails++;
      print_verdict;
    end
  end

  // oldest expected result is compared whenever a result appears
  always @(negedge clk)
    if (result_valid === 1'b1)
    begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h3FFFFFFFF;
      chk({result_ch, result}, e);
    end

  task wait_tick;
    int k;
    k = 0;
    while (tick !== 1'b1 && k < 2 * TK)
    begin
      @(negedge clk);
      k++;
    end
    if (tick !== 1'b1)
      fails++;
    @(negedge clk);
  endtask

  // two ticks move every pending count into the accumulators
  task settle;
    wait_tick;
    wait_tick;
  endtask

  task run_table(input logic s);
    table_skipped = s;
    table_start = 1'b1;
    @(negedge clk);
    table_start = 1'b0;
    table_skipped = 1'b0;
    @(negedge clk);
  endtask

  task read_ch(input logic [1:0] c, input logic signed [15:0] m,
               input logic signed [31:0] o, input int cnt);
    exp_q.push_back({c, 32'(cnt * m + o)});
    instr_ch = c;
    multiplier = m;
    offset = o;
    instr_exec = 1'b1;
    @(negedge clk);
    instr_exec = 1'b0;
    @(negedge clk);
  endtask

  initial
  begin
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    cfg_code = 32'h00010200;
    @(negedge clk);
    chk(34'(chan_unavail), 34'h0);
    run_table(1'b0);
    n = 1 + ($random(seed) & 7);
    repeat (n) u_pulse_source.hf(0);
    repeat (3) u_pulse_source.ac(2);
    repeat (2) u_pulse_source.sw(1, 10, 10);
    // a short open between closures counts once
    u_pulse_source.sw(1, 10, 2);
    u_pulse_source.sw(1, 10, 10);
    settle;
    run_table(1'b0);
    read_ch(2'h0, 16'($random(seed) % 100), $random(seed), n);
    read_ch(2'h1, 16'h0001, 32'h0, 3);
    read_ch(2'h2, 16'h0001, 32'h0, 3);
    read_ch(2'h3, 16'h0001, 32'h0, 0);
    run_table(1'b0);
    read_ch(2'h0, 16'h0001, 32'h0, 0);
    cfg_code[7:0] = 8'h0A;
    repeat (3) u_pulse_source.hf(0);
    settle;
    run_table(1'b0);
    read_ch(2'h0, 16'h0001, 32'h0, 3);
    repeat (5) u_pulse_source.hf(0);
    settle;
    run_table(1'b1);
    read_ch(2'h0, 16'h0001, 32'h0, 3);
    run_table(1'b0);
    read_ch(2'h0, 16'h0001, 32'h0, 0);
    cfg_code[7:0] = 8'h14;
    interval_s = 16'h0002 + 16'($random(seed) & 3);
    repeat (5) u_pulse_source.hf(0);
    settle;
    run_table(1'b0);
    read_ch(2'h0, 16'h0001, 32'h0, 5 / interval_s);
    cfg_code = {8'($random(seed) & 1), 8'h04, 8'h00, 8'h03};
    interval_s = 16'h0001;
    repeat (2) @(negedge clk);
    chk(34'(chan_unavail), 34'hA);
    repeat (4) u_pulse_source.hf(0);
    repeat (3) u_pulse_source.hf(1);
    repeat (2) u_pulse_source.ac(2);
    settle;
    run_table(1'b0);
    read_ch(2'h0, 16'h0001, 32'h0, 4);
    read_ch(2'h2, 16'h0001, 32'h0, 2);
    cfg_code = 32'h0;
    repeat (2) u_pulse_source.hf(3);
    time_changed = 1'b1;
    @(negedge clk);
    time_changed = 1'b0;
    u_pulse_source.hf(3);
    settle;
    run_table(1'b0);
    read_ch(2'h3, 16'h0001, 32'h0, 3);
    repeat (3) @(negedge clk);
    print_verdict;
  end
endmodule // tb_pulse_count_accumulator

`default_nettype wire
